// file: test_usb_endpoint_buffer_handshake.sv
// self-checking bench for the endpoint buffer and handshake block
// assumes the far-side model drives tokens, completions and answers
`timescale 1ns/10ps
module test_usb_endpoint_buffer_handshake;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic perr;
  logic [31:0] rd;
  usb_ep_pkg::dev_req_t dev_req;
  usb_ep_pkg::dev_resp_t dev_resp;
  usb_ep_pkg::dev_done_t dev_done;
  usb_ep_pkg::host_cmd_t host_cmd;
  usb_ep_pkg::host_done_t host_done;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #25 clk_sys = ~clk_sys;
  usb_endpoint_buffer_handshake #(.ADDR_W(12))
      usb_endpoint_buffer_handshake_i (.clk_sys(clk_sys), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dev_req(dev_req), .dev_resp(dev_resp), .dev_done(dev_done),
    .host_cmd(host_cmd), .host_done(host_done));
  usb_peer_model usb_peer_model_i (.clk_sys(clk_sys), .dev_req(dev_req),
    .dev_resp(dev_resp), .dev_done(dev_done), .host_cmd(host_cmd),
    .host_done(host_done));
  // ----------------------------------------
  // shared helpers; register index i sits at byte address 4*i
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [9:0] i,
      input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {i, 2'b00};
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1); // no local limit: a lost answer hits timeout
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    apb(1'b1, i, d);
  endtask : wr
  task automatic rdc(input logic [9:0] i, input logic [31:0] exp);
    apb(1'b0, i, 32'h0);
    chk(rd, exp);
  endtask : rdc
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_regs();
    rdc(10'h001, 32'h80);
    rdc(10'h00d, 32'h00);
    rdc(10'h028, 32'h00);
    rdc(10'h02e, 32'h00);
    wr(10'h038, 32'hff);
    rdc(10'h038, 32'hdf);
    apb(1'b0, 10'h3ff, 32'h0);
    chk({perr, rd}, 33'h1_0000_0000);
    $display("test_regs done");
  endtask : test_regs
  // every enable pair on every endpoint; bit 15 of base must be dropped
  task automatic test_layout();
    logic [15:0] b;
    logic [7:0] n;
    usb_ep_pkg::dev_resp_t r;
    for (int k = 0; k < 3; k++) begin
      b = 16'(32'h8080 + k * 256);
      n = 8'(8'hfe + k);
      wr(10'(10'h030 + k), 32'(b));
      wr(10'(10'h034 + k), 32'(n));
      wr(10'(10'h038 + k), 32'h0);
      for (int m = 0; m < 4; m++) begin
        wr(10'h03c, 32'(m << (2 * k)));
        usb_peer_model_i.token(2'(k), 1'b0, r);
        chk({r.valid, r.access}, {1'b1, m[1]});
        if (m[1]) chk(r.buf_addr, b[14:0]);
        usb_peer_model_i.token(2'(k), 1'b1, r);
        chk({r.valid, r.access}, {1'b1, m[0]});
        if (m[0]) chk({r.len, r.buf_addr},
          {n, b[14:0] + (m[1] ? 15'h0040 : 15'h0000)});
      end
    end
    $display("test_layout done");
  endtask : test_layout
  task automatic test_resp();
    usb_ep_pkg::dev_resp_t r;
    wr(10'h03c, 32'h3);
    for (int c = 0; c < 4; c++) begin
      wr(10'h038, 32'({c[0], c[1], 2'b00, c[1:0], ~c[1:0]}));
      usb_peer_model_i.token(2'd0, 1'b0, r);
      chk({r.handshake, r.data1}, {c[1:0], c[0]});
      usb_peer_model_i.token(2'd0, 1'b1, r);
      chk({r.handshake, r.data1}, {~c[1:0], c[1]});
    end
    // endpoint code 3 falls back to endpoint 5
    usb_peer_model_i.token(2'd3, 1'b1, r);
    chk({r.handshake, r.data1}, {2'b00, 1'b1});
    $display("test_resp done");
  endtask : test_resp
  task automatic test_auto();
    wr(10'h038, 32'h10);
    usb_peer_model_i.finish(2'd0, 1'b1, 1'b1);
    rdc(10'h038, 32'h50);
    usb_peer_model_i.finish(2'd0, 1'b0, 1'b1);
    rdc(10'h038, 32'hd0);
    usb_peer_model_i.finish(2'd0, 1'b0, 1'b0);
    rdc(10'h038, 32'hd0);
    wr(10'h039, 32'h40);
    usb_peer_model_i.finish(2'd1, 1'b1, 1'b1);
    rdc(10'h039, 32'h40);
    $display("test_auto done");
  endtask : test_auto
  // setup, out, in, then a refused in; toggles tracked here
  task automatic test_host();
    logic [3:0] p;
    logic ok, tx, rx, tog;
    int n;
    usb_ep_pkg::host_cmd_t c;
    tx = 1'b1;
    rx = 1'b1;
    wr(10'h00d, 32'h48);
    wr(10'h018, 32'h9200);
    wr(10'h01c, 32'h1300);
    wr(10'h02c, 32'h40);
    wr(10'h02e, 32'h50);
    wr(10'h02a, 32'h90);
    for (int i = 0; i < 4; i++) begin
      p = (i == 0) ? 4'hd : (i == 1) ? 4'h1 : 4'h9;
      ok = (i != 3);
      tog = rx;
      usb_peer_model_i.rsp_ok = ok;
      usb_peer_model_i.rsp_pid = ok ? 4'h2 : 4'ha;
      usb_peer_model_i.rsp_count = 7'(i * 20 + 4);
      wr(10'h028, {24'h0, p, 4'h3});
      n = 0;
      do begin
        apb(1'b0, 10'h03d, 32'h0);
        n++;
      end while (rd[1] !== 1'b1 && n < 20);
      chk(rd, {25'h0, tog, 6'b000010});
      c = usb_peer_model_i.last_cmd;
      chk({c.ep, c.pid, c.tx_data1, c.rx_data1}, {4'h3, p, tx, rx});
      chk({c.tx_access, c.rx_access, c.tx_addr, c.rx_addr,
        c.tx_len}, {2'b11, 15'h1300, 15'h1200, 8'h40});
      apb(1'b0, 10'h03e, 32'h0);
      chk({rd[6], rd[3:0]}, {tog, ok ? 4'h2 : 4'ha});
      if (p == 4'h9) rdc(10'h03f, 32'(i * 20 + 4));
      if (ok && p != 4'h9) tx = ~tx;
      if (ok && p == 4'h9) rx = ~rx;
      rdc(10'h02e, {25'h0, tx, 6'h10});
      rdc(10'h02a, {24'h0, rx, 7'h10});
      wr(10'h03d, 32'h42);
      rdc(10'h03d, 32'h0);
    end
    $display("test_host done");
  endtask : test_host
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    test_regs();
    test_layout();
    test_resp();
    test_auto();
    test_host();
    give_verdict();
  end
  // about 400 cycles expected; the ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
  end
endmodule : test_usb_endpoint_buffer_handshake

// file: usb_endpoint_buffer_handshake.sv
// register file, buffer layout, toggles and handshake choice for
// endpoints 5..7 and the host endpoint pair
// assumes a packet engine that presents tokens and reports completions
`timescale 1ns/10ps
module usb_endpoint_buffer_handshake #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire usb_ep_pkg::dev_req_t dev_req,
  output usb_ep_pkg::dev_resp_t dev_resp,
  input wire usb_ep_pkg::dev_done_t dev_done,
  output usb_ep_pkg::host_cmd_t host_cmd,
  input wire usb_ep_pkg::host_done_t host_done
);
  // ---------------------------------------------------------------
  // address helpers
  // ---------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] addr_of(input logic [31:0] idx);
    logic [31:0] b;
    b = idx << 2;
    return b[ADDR_W-1:0];
  endfunction : addr_of

  function automatic logic [ADDR_W-1:0] step(input logic [31:0] idx,
                                             input logic [1:0] k);
    return addr_of(idx + {30'h0, k});
  endfunction : step

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0] ep_base_q [3];
  logic [7:0] ep_tlen_q [3];
  logic [7:0] ep_ctrl_q [3];
  logic [7:0] upper_mode_q;
  logic [7:0] port_ctrl_q, host_mode_q, aux_q, token_q;
  logic [7:0] hrx_ctrl_q, htx_ctrl_q, htx_len_q;
  logic [15:0] hrx_base_q, htx_base_q;
  logic done_flag_q, tog_flag_q;
  logic [3:0] resp_pid_q;
  logic tog_stat_q;
  logic [6:0] rx_count_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  usb_ep_pkg::dev_resp_t dev_resp_q;
  usb_ep_pkg::host_cmd_t host_cmd_q;

  // ---------------------------------------------------------------
  // apb decode: data is prepared in setup, answered in first access
  // ---------------------------------------------------------------
  wire setup_ph = psel & ~penable;
  wire wr_fire = psel & penable & pready_q & pwrite;
  wire [7:0] wb = pwdata[7:0];
  wire [15:0] ww = pwdata[15:0];
  wire hit_port = paddr == addr_of(usb_ep_pkg::IDX_HOST_PORT_CONTROL);
  wire hit_hmode = paddr == addr_of(usb_ep_pkg::IDX_HOST_ENDPOINT_MODE);
  wire hit_hrxb = paddr == addr_of(usb_ep_pkg::IDX_HOST_RX_BUFFER_BASE);
  wire hit_htxb = paddr == addr_of(usb_ep_pkg::IDX_HOST_TX_BUFFER_BASE);
  wire hit_aux = paddr == addr_of(usb_ep_pkg::IDX_HOST_AUX_SETTING);
  wire hit_tok = paddr == addr_of(usb_ep_pkg::IDX_HOST_TOKEN_SETTING);
  wire hit_hrxc =
    paddr == addr_of(usb_ep_pkg::IDX_HOST_RX_ENDPOINT_CONTROL);
  wire hit_htxl = paddr == addr_of(usb_ep_pkg::IDX_HOST_TX_LENGTH);
  wire hit_htxc =
    paddr == addr_of(usb_ep_pkg::IDX_HOST_TX_ENDPOINT_CONTROL);
  wire hit_umode = paddr == addr_of(usb_ep_pkg::IDX_UPPER_ENDPOINT_MODE);
  wire hit_flag = paddr == addr_of(usb_ep_pkg::IDX_INTERRUPT_FLAG);
  wire hit_stat = paddr == addr_of(usb_ep_pkg::IDX_INTERRUPT_STATUS);
  wire hit_rxc = paddr == addr_of(usb_ep_pkg::IDX_RECEIVED_BYTE_COUNT);
  logic [2:0] hit_base, hit_tlen, hit_ctrl;
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      hit_base[k] = paddr == step(usb_ep_pkg::IDX_ENDPOINT_BUFFER_BASE5,
                                  2'(k));
      hit_tlen[k] = paddr == step(usb_ep_pkg::IDX_ENDPOINT_TX_LENGTH5,
                                  2'(k));
      hit_ctrl[k] = paddr == step(usb_ep_pkg::IDX_ENDPOINT_CONTROL5,
                                  2'(k));
    end
  end
  wire hit_any = hit_port | hit_hmode | hit_hrxb | hit_htxb | hit_aux |
                 hit_tok | hit_hrxc | hit_htxl | hit_htxc | hit_umode |
                 hit_flag | hit_stat | hit_rxc | (|hit_base) |
                 (|hit_tlen) | (|hit_ctrl);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    for (int k = 0; k < 3; k++) begin
      if (hit_base[k]) rd_mux = {16'h0000, ep_base_q[k]};
      if (hit_tlen[k]) rd_mux = {24'h00_0000, ep_tlen_q[k]};
      if (hit_ctrl[k]) rd_mux = {24'h00_0000, ep_ctrl_q[k]};
    end
    if (hit_port) rd_mux = {24'h00_0000, port_ctrl_q};
    if (hit_hmode) rd_mux = {24'h00_0000, host_mode_q};
    if (hit_hrxb) rd_mux = {16'h0000, hrx_base_q};
    if (hit_htxb) rd_mux = {16'h0000, htx_base_q};
    if (hit_aux) rd_mux = {24'h00_0000, aux_q};
    if (hit_tok) rd_mux = {24'h00_0000, token_q};
    if (hit_hrxc) rd_mux = {24'h00_0000, hrx_ctrl_q};
    if (hit_htxl) rd_mux = {24'h00_0000, htx_len_q};
    if (hit_htxc) rd_mux = {24'h00_0000, htx_ctrl_q};
    if (hit_umode) rd_mux = {24'h00_0000, 2'h0, upper_mode_q[5:0]};
    if (hit_flag) rd_mux = {24'h00_0000, 1'h0, tog_flag_q, 4'h0,
                            done_flag_q, 1'h0};
    if (hit_stat) rd_mux = {24'h00_0000, 1'h0, tog_stat_q, 2'h0,
                            resp_pid_q};
    if (hit_rxc) rd_mux = {25'h000_0000, rx_count_q};
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup_ph;
      pslverr_q <= setup_ph & ~hit_any;
      prdata_q <= setup_ph ? rd_mux : prdata_q;
    end
  end

  // ---------------------------------------------------------------
  // endpoint 5..7 control: software writes, hardware flips on top
  // so a flip landing with a write is not lost
  // ---------------------------------------------------------------
  logic [7:0] ep_ctrl_d [3];
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      ep_ctrl_d[k] = (wr_fire && hit_ctrl[k]) ? wb : ep_ctrl_q[k];
      ep_ctrl_d[k][5] = 1'b0;
      if (dev_done.valid && dev_done.ok && dev_done.ep == 2'(k) &&
          ep_ctrl_q[k][usb_ep_pkg::CTRL_AUTO]) begin
        if (dev_done.is_in)
          ep_ctrl_d[k][usb_ep_pkg::CTRL_TX_TOG] =
            ~ep_ctrl_d[k][usb_ep_pkg::CTRL_TX_TOG];
        else
          ep_ctrl_d[k][usb_ep_pkg::CTRL_RX_TOG] =
            ~ep_ctrl_d[k][usb_ep_pkg::CTRL_RX_TOG];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int k = 0; k < 3; k++) begin
        ep_base_q[k] <= usb_ep_pkg::RST_WORD;
        ep_tlen_q[k] <= usb_ep_pkg::RST_BYTE;
        ep_ctrl_q[k] <= usb_ep_pkg::RST_BYTE;
      end
      upper_mode_q <= usb_ep_pkg::RST_BYTE;
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (wr_fire && hit_base[k]) ep_base_q[k] <= ww;
        if (wr_fire && hit_tlen[k]) ep_tlen_q[k] <= wb;
        ep_ctrl_q[k] <= ep_ctrl_d[k];
      end
      if (wr_fire && hit_umode) upper_mode_q <= {2'h0, wb[5:0]};
    end
  end

  // ---------------------------------------------------------------
  // device response: layout and handshake for the token presented
  // ---------------------------------------------------------------
  wire [1:0] rq_ep = dev_req.ep == 2'h3 ? 2'h0 : dev_req.ep;
  wire rq_rx_en = upper_mode_q[{rq_ep, 1'b1}];
  wire rq_tx_en = upper_mode_q[{rq_ep, 1'b0}];
  wire [7:0] rq_ctrl = ep_ctrl_q[rq_ep];
  wire [14:0] rq_base = ep_base_q[rq_ep][usb_ep_pkg::BASE_BITS-1:0];
  // transmit goes above the receive buffer only when that one exists
  wire [14:0] rq_tx_addr =
    rq_rx_en ? rq_base + usb_ep_pkg::BUF_BYTES : rq_base;
  wire rq_access =
    dev_req.is_in ? rq_tx_en : rq_rx_en;
  usb_ep_pkg::dev_resp_t resp_d;
  always_comb begin
    resp_d.valid = dev_req.valid;
    resp_d.access = dev_req.valid & rq_access;
    resp_d.handshake = dev_req.is_in ? rq_ctrl[1:0] : rq_ctrl[3:2];
    resp_d.data1 = dev_req.is_in ? rq_ctrl[usb_ep_pkg::CTRL_TX_TOG] :
                                   rq_ctrl[usb_ep_pkg::CTRL_RX_TOG];
    resp_d.buf_addr = dev_req.is_in ? rq_tx_addr : rq_base;
    resp_d.len = dev_req.is_in ? ep_tlen_q[rq_ep] : 8'h00;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dev_resp_q <= '0;
    end else begin
      dev_resp_q <= resp_d;
    end
  end

  // ---------------------------------------------------------------
  // host endpoint pair
  // ---------------------------------------------------------------
  wire hd_ok = host_done.valid & host_done.ok;
  wire flip_htx = hd_ok & ~host_done.is_in &
                  htx_ctrl_q[usb_ep_pkg::CTRL_AUTO];
  wire flip_hrx = hd_ok & host_done.is_in &
                  hrx_ctrl_q[usb_ep_pkg::CTRL_AUTO];
  logic [7:0] hrx_ctrl_d, htx_ctrl_d;
  always_comb begin
    hrx_ctrl_d = (wr_fire && hit_hrxc) ? wb : hrx_ctrl_q;
    htx_ctrl_d = (wr_fire && hit_htxc) ? wb : htx_ctrl_q;
    hrx_ctrl_d[usb_ep_pkg::CTRL_RX_TOG] =
      hrx_ctrl_d[usb_ep_pkg::CTRL_RX_TOG] ^ flip_hrx;
    htx_ctrl_d[usb_ep_pkg::CTRL_TX_TOG] =
      htx_ctrl_d[usb_ep_pkg::CTRL_TX_TOG] ^ flip_htx;
  end
  // a completion wins over a software clear in the same cycle
  wire clr_done = wr_fire & hit_flag & wb[usb_ep_pkg::FLAG_DONE];
  wire clr_tog = wr_fire & hit_flag & wb[usb_ep_pkg::FLAG_TOG_OK];

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      port_ctrl_q <= usb_ep_pkg::RST_PORT_CONTROL;
      host_mode_q <= usb_ep_pkg::RST_BYTE;
      aux_q <= usb_ep_pkg::RST_BYTE;
      token_q <= usb_ep_pkg::RST_BYTE;
      hrx_ctrl_q <= usb_ep_pkg::RST_BYTE;
      htx_ctrl_q <= usb_ep_pkg::RST_BYTE;
      htx_len_q <= usb_ep_pkg::RST_BYTE;
      hrx_base_q <= usb_ep_pkg::RST_WORD;
      htx_base_q <= usb_ep_pkg::RST_WORD;
      done_flag_q <= 1'b0;
      tog_flag_q <= 1'b0;
      resp_pid_q <= 4'h0;
      tog_stat_q <= 1'b0;
      rx_count_q <= 7'h00;
    end else begin
      if (wr_fire && hit_port) port_ctrl_q <= wb;
      if (wr_fire && hit_hmode) host_mode_q <= {1'b0, wb[6], 1'b0,
                                                wb[4:3], 2'h0, wb[0]};
      if (wr_fire && hit_aux) aux_q <= wb;
      if (wr_fire && hit_tok) token_q <= wb;
      if (wr_fire && hit_htxl) htx_len_q <= wb;
      if (wr_fire && hit_hrxb) hrx_base_q <= ww;
      if (wr_fire && hit_htxb) htx_base_q <= ww;
      hrx_ctrl_q <= hrx_ctrl_d;
      htx_ctrl_q <= htx_ctrl_d;
      done_flag_q <= host_done.valid | (done_flag_q & ~clr_done);
      tog_flag_q <= (host_done.valid & host_done.tog_ok) |
                    (tog_flag_q & ~clr_tog);
      if (host_done.valid) begin
        resp_pid_q <= host_done.pid;
        tog_stat_q <= host_done.tog_ok;
        if (host_done.is_in) rx_count_q <= host_done.rx_count;
      end
    end
  end

  // a token write launches the transaction; setup and out read the
  // transmit buffer, in fills the receive buffer
  usb_ep_pkg::host_cmd_t cmd_d;
  always_comb begin
    cmd_d.go = wr_fire & hit_tok;
    cmd_d.ep = wb[3:0];
    cmd_d.pid = wb[7:4];
    cmd_d.tx_access = host_mode_q[usb_ep_pkg::HMODE_TX_EN];
    cmd_d.rx_access = host_mode_q[usb_ep_pkg::HMODE_RX_EN];
    cmd_d.tx_addr = htx_base_q[usb_ep_pkg::BASE_BITS-1:0];
    cmd_d.rx_addr = hrx_base_q[usb_ep_pkg::BASE_BITS-1:0];
    cmd_d.tx_len = htx_len_q;
    cmd_d.tx_data1 = htx_ctrl_q[usb_ep_pkg::CTRL_TX_TOG];
    cmd_d.rx_data1 = hrx_ctrl_q[usb_ep_pkg::CTRL_RX_TOG];
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      host_cmd_q <= '0;
    end else begin
      host_cmd_q <= cmd_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign dev_resp = dev_resp_q;
  assign host_cmd = host_cmd_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_DISABLED_NO_ACCESS: assert property (
    @(posedge clk_sys) disable iff (reset)
    dev_req.valid && !rq_rx_en && !rq_tx_en |=> !dev_resp.access)
    else $error("disabled endpoint granted buffer access");
  AST_TX_ABOVE_RX: assert property (
    @(posedge clk_sys) disable iff (reset)
    dev_req.valid && dev_req.is_in && rq_rx_en && rq_tx_en |=>
    dev_resp.buf_addr == $past(rq_base) + 15'h0040)
    else $error("transmit buffer not 64 bytes above base");
  AST_RX_AT_BASE: assert property (
    @(posedge clk_sys) disable iff (reset)
    dev_req.valid && !dev_req.is_in |=>
    dev_resp.buf_addr == $past(rq_base))
    else $error("receive buffer not at base");
  AST_OUT_HANDSHAKE: assert property (
    @(posedge clk_sys) disable iff (reset)
    dev_req.valid && !dev_req.is_in |=>
    dev_resp.handshake == $past(rq_ctrl[3:2]) &&
    dev_resp.data1 == $past(rq_ctrl[7]))
    else $error("out answer not taken from control");
  AST_IN_HANDSHAKE: assert property (
    @(posedge clk_sys) disable iff (reset)
    dev_req.valid && dev_req.is_in |=>
    dev_resp.handshake == $past(rq_ctrl[1:0]) &&
    dev_resp.data1 == $past(rq_ctrl[6]) &&
    dev_resp.len == $past(ep_tlen_q[rq_ep]))
    else $error("in answer not taken from control");
  AST_AUTO_FLIP: assert property (
    @(posedge clk_sys) disable iff (reset)
    dev_done.valid && dev_done.ok && !dev_done.is_in &&
    ep_ctrl_q[dev_done.ep][4] && !(wr_fire && |hit_ctrl) |=>
    ep_ctrl_q[$past(dev_done.ep)][7] != $past(ep_ctrl_q[dev_done.ep][7]))
    else $error("receive toggle did not flip");
  AST_DONE_SETS: assert property (
    @(posedge clk_sys) disable iff (reset)
    host_done.valid |=> done_flag_q && resp_pid_q == $past(host_done.pid))
    else $error("host completion not recorded");
  AST_HOST_FLIP: assert property (
    @(posedge clk_sys) disable iff (reset)
    flip_htx && !(wr_fire && hit_htxc) |=> htx_ctrl_q[6] != $past(
    htx_ctrl_q[6]))
    else $error("host transmit toggle did not flip");
  AST_HOST_RX_FLIP: assert property (
    @(posedge clk_sys) disable iff (reset)
    flip_hrx && !(wr_fire && hit_hrxc) |=> hrx_ctrl_q[7] != $past(
    hrx_ctrl_q[7]))
    else $error("host receive toggle did not flip");
  AST_RX_COUNT: assert property (
    @(posedge clk_sys) disable iff (reset)
    host_done.valid && host_done.is_in |=>
    rx_count_q == $past(host_done.rx_count))
    else $error("received byte count not recorded");
  AST_TOG_STATUS: assert property (
    @(posedge clk_sys) disable iff (reset)
    host_done.valid |=> tog_stat_q == $past(host_done.tog_ok) &&
    (tog_flag_q | ~tog_stat_q))
    else $error("toggle match not reported");
  AST_TOKEN_GO: assert property (
    @(posedge clk_sys) disable iff (reset)
    wr_fire && hit_tok |=> host_cmd.go && host_cmd.pid == $past(wb[7:4])
    ##1 !host_cmd.go)
    else $error("token write did not launch one transaction");
endmodule : usb_endpoint_buffer_handshake

// file: usb_ep_pkg.sv
// constants, field layouts and carriers for the endpoint buffer block
// assumes an APB master on the register side and a packet engine beside it
package usb_ep_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [31:0] IDX_HOST_PORT_CONTROL = 32'h4000_8001;
  localparam logic [31:0] IDX_HOST_ENDPOINT_MODE = 32'h4000_800d;
  localparam logic [31:0] IDX_HOST_RX_BUFFER_BASE = 32'h4000_8018;
  localparam logic [31:0] IDX_HOST_TX_BUFFER_BASE = 32'h4000_801c;
  localparam logic [31:0] IDX_HOST_AUX_SETTING = 32'h4000_8026;
  localparam logic [31:0] IDX_HOST_TOKEN_SETTING = 32'h4000_8028;
  localparam logic [31:0] IDX_HOST_RX_ENDPOINT_CONTROL = 32'h4000_802a;
  localparam logic [31:0] IDX_HOST_TX_LENGTH = 32'h4000_802c;
  localparam logic [31:0] IDX_HOST_TX_ENDPOINT_CONTROL = 32'h4000_802e;
  localparam logic [31:0] IDX_ENDPOINT_BUFFER_BASE5 = 32'h4000_8030;
  localparam logic [31:0] IDX_ENDPOINT_TX_LENGTH5 = 32'h4000_8034;
  localparam logic [31:0] IDX_ENDPOINT_CONTROL5 = 32'h4000_8038;
  localparam logic [31:0] IDX_UPPER_ENDPOINT_MODE = 32'h4000_803c;
  localparam logic [31:0] IDX_INTERRUPT_FLAG = 32'h4000_803d;
  localparam logic [31:0] IDX_INTERRUPT_STATUS = 32'h4000_803e;
  localparam logic [31:0] IDX_RECEIVED_BYTE_COUNT = 32'h4000_803f;
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_RX_TOG = 7;
  localparam int CTRL_TX_TOG = 6;
  localparam int CTRL_AUTO = 4;
  localparam int HMODE_TX_EN = 6;
  localparam int HMODE_RX_EN = 3;
  localparam int FLAG_DONE = 1;
  localparam int FLAG_TOG_OK = 6;
  localparam int BASE_BITS = 15;
  localparam logic [14:0] BUF_BYTES = 15'h0040;
  localparam logic [7:0] RST_PORT_CONTROL = 8'h80;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [1:0] RESP_ACK = 2'h0;
  localparam logic [1:0] RESP_NONE = 2'h1;
  localparam logic [1:0] RESP_NAK = 2'h2;
  localparam logic [1:0] RESP_STALL = 2'h3;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [1:0] ep;     // 0..2 stands for endpoint 5..7
    logic is_in;
  } dev_req_t;
  typedef struct packed {
    logic valid;
    logic access;       // buffer may be touched
    logic [1:0] handshake;
    logic data1;        // pid expected (out) or sent (in)
    logic [14:0] buf_addr;
    logic [7:0] len;
  } dev_resp_t;
  typedef struct packed {
    logic valid;
    logic [1:0] ep;
    logic is_in;
    logic ok;
  } dev_done_t;
  typedef struct packed {
    logic go;
    logic [3:0] ep;
    logic [3:0] pid;
    logic tx_access;
    logic rx_access;
    logic [14:0] tx_addr;
    logic [14:0] rx_addr;
    logic [7:0] tx_len;
    logic tx_data1;
    logic rx_data1;
  } host_cmd_t;
  typedef struct packed {
    logic valid;
    logic ok;
    logic is_in;
    logic tog_ok;
    logic [3:0] pid;
    logic [6:0] rx_count;
  } host_done_t;
endpackage : usb_ep_pkg

// file: usb_peer_model.sv
// far-side packet engine model: device tokens, completions, host answers
// assumes clk_sys from the bench and registered outputs of the block
`timescale 1ns/10ps
module usb_peer_model (
  input wire logic clk_sys,
  output usb_ep_pkg::dev_req_t dev_req,
  input wire usb_ep_pkg::dev_resp_t dev_resp,
  output usb_ep_pkg::dev_done_t dev_done,
  input wire usb_ep_pkg::host_cmd_t host_cmd,
  output usb_ep_pkg::host_done_t host_done
);
  usb_ep_pkg::host_cmd_t last_cmd;
  logic [3:0] rsp_pid = 4'h2;
  logic [6:0] rsp_count = 7'h00;
  logic rsp_ok = 1'b1;
  logic peer_data1 = 1'b1;
  int rsp_delay = 3;
  initial begin
    dev_req = '0;
    dev_done = '0;
    host_done = '0;
  end
  // ----------------------------------------
  // device role
  // ----------------------------------------
  task automatic token(input logic [1:0] ep, input logic is_in,
      output usb_ep_pkg::dev_resp_t r);
    @(posedge clk_sys);
    dev_req <= '{1'b1, ep, is_in};
    @(posedge clk_sys);
    dev_req <= '0;
    // the answer stands one cycle; take it at the edge that ends it
    @(posedge clk_sys);
    r = dev_resp;
  endtask : token
  task automatic finish(input logic [1:0] ep, input logic is_in,
      input logic ok);
    @(posedge clk_sys);
    dev_done <= '{1'b1, ep, is_in, ok};
    @(posedge clk_sys);
    dev_done <= '0;
  endtask : finish
  // ----------------------------------------
  // host role: answer each issued token late, never at once
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (host_cmd.go === 1'b1) begin
      last_cmd = host_cmd;
      repeat (rsp_delay) @(posedge clk_sys);
      // counts stay within one 64-byte packet
      host_done <= '{1'b1, rsp_ok, last_cmd.pid == 4'h9,
        last_cmd.rx_data1 == peer_data1, rsp_pid, rsp_count};
      @(posedge clk_sys);
      host_done <= '0;
    end
  end
endmodule : usb_peer_model
